// ---- common/twi_slave_pkg.sv ----
// Purpose: shared constants for the two-wire slave register port
// Assumes: system clock of 10 MHz, bus clock far slower
// Notes:   register map holds sixteen byte-wide registers
package twi_slave_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h15;
  localparam int         NUM_REGS      = 16;
  localparam int         PTR_W         = 4;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [3:0] BIT_CNT_LAST  = 4'h7;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [7:0] SWRST_REG_IDX = 8'h01;
  localparam int         SWRST_BIT_POS = 4;
endpackage

// ---- src/twi_sync2.sv ----
// Purpose: two-flop synchroniser for one pin level
// Assumes: input asynchronous to sys_clk_i
// Notes:   resets to the idle high level of the bus
`timescale 1ns/1ps
module twi_sync2
(
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb
  begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;
endmodule

// ---- src/twi_regfile.sv ----
// Purpose: byte-wide user register storage addressed by index
// Assumes: one write strobe per byte from the serial port
// Notes:   read data is combinational from the flip-flops
`timescale 1ns/1ps
module twi_regfile
#(
  parameter int NUM_REGS = twi_slave_pkg::NUM_REGS,
  parameter int PTR_W    = twi_slave_pkg::PTR_W
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             wr_en_i,
  input  wire logic [PTR_W-1:0] wr_idx_i,
  input  wire logic [7:0]       wr_data_i,
  input  wire logic [PTR_W-1:0] rd_idx_i,
  output logic      [7:0]       rd_data_o
);
  logic [7:0] mem_ff  [NUM_REGS];
  logic [7:0] nxt_mem [NUM_REGS];

  initial
  begin
    if (NUM_REGS > (1 << PTR_W) || NUM_REGS < 1)
      $error("twi_regfile: NUM_REGS does not fit PTR_W");
  end

  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      nxt_mem[i] = mem_ff[i];
      if (wr_en_i && (int'(wr_idx_i) == i))
        nxt_mem[i] = wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        mem_ff[i] <= twi_slave_pkg::REG_RESET_VAL;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
        mem_ff[i] <= nxt_mem[i];
    end
  end

  assign rd_data_o = (int'(rd_idx_i) < NUM_REGS) ? mem_ff[rd_idx_i] : 8'h00;
endmodule

// ---- src/twi_slave.sv ----
// Purpose: two-wire bus slave with register pointer and byte access
// Assumes: scl and sda pins are sampled by sys_clk_i through two flops
// Notes:   software reset leaves this port running until the transfer ends
//
// Contract
// [RULE1] slave only; clock line never driven
// [RULE2] data line sampled; driven open-drain only
// [RULE3] data changes only while clock low
// [RULE4] falling data, clock high: start; rising: stop
// [RULE5] idle bus lines stay released high
// [RULE6] bytes of eight bits, MSB first
// [RULE7] master gives nine clocks per byte
// [RULE8] transmitter releases; receiver holds ninth low
// [RULE9] master may stop after missing acknowledge
// [RULE10] master leaves final read byte unacknowledged
// [RULE11] release data line after read not acknowledged
// [RULE12] repeated start begins new address phase
// [RULE13] first byte: address 15h plus direction
// [RULE14] matching address acknowledged, direction chosen
// [RULE15] first written byte loads register pointer
// [RULE16] further written bytes stored at pointer
// [RULE17] pointer advances after each written byte
// [RULE18] master writes pointer, restarts, then reads
// [RULE19] read sends pointed register, pointer advances
// [RULE20] master avoids both lines low 10 ms
// [RULE21] software reset spares serial port logic
// [RULE22] pointer addresses sixteen registers 0x00-0x0f
// [RULE23] mismatched address ignored until next start
// [RULE24] start or stop mid-byte abandons byte
`timescale 1ns/1ps
module twi_slave
#(
  parameter int NUM_REGS = twi_slave_pkg::NUM_REGS,
  parameter int PTR_W    = twi_slave_pkg::PTR_W
)
(
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      software_reset_bit_o,
  output logic      busy_o
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_RX    = 6'b000100,
    ST_TX    = 6'b001000,
    ST_ACK   = 6'b010000,
    ST_MACK  = 6'b100000
  } state_t;

  logic scl_s;
  logic sda_s;
  logic scl_d_ff;
  logic sda_d_ff;

  // both pins pass two flops before use; clock line is input only
  twi_sync2 u_sync_scl (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .async_i(scl_i), .sync_o(scl_s)); // [RULE1]
  twi_sync2 u_sync_sda (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .async_i(sda_i), .sync_o(sda_s)); // [RULE2]

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_comb
  begin
    scl_rise  = scl_s & ~scl_d_ff;
    scl_fall  = ~scl_s & scl_d_ff;
    start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s; // [RULE4]
    stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s; // [RULE4]
  end

  state_t           state_ff;
  state_t           nxt_state;
  logic [3:0]       bit_cnt_ff;
  logic [3:0]       nxt_bit_cnt;
  logic [7:0]       shift_ff;
  logic [7:0]       nxt_shift;
  logic [PTR_W-1:0] ptr_ff;
  logic [PTR_W-1:0] nxt_ptr;
  logic             ptr_loaded_ff;
  logic             nxt_ptr_loaded;
  logic             rd_mode_ff;
  logic             nxt_rd_mode;
  logic             sda_drv_ff;
  logic             nxt_sda_drv;
  logic             busy_ff;
  logic             nxt_busy;
  logic             swrst_ff;
  logic             nxt_swrst;
  logic             ack_pend_ff;
  logic             nxt_ack_pend;
  logic             wr_en;
  logic [7:0]       rd_data;

  // one pointer reaches the whole map; reads past the map give zero
  twi_regfile #(.NUM_REGS(NUM_REGS), .PTR_W(PTR_W)) u_regs
  (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (wr_en),
    .wr_idx_i  (ptr_ff),
    .wr_data_i (shift_ff),
    .rd_idx_i  (ptr_ff), // [RULE22]
    .rd_data_o (rd_data)
  );

  initial
  begin
    if (PTR_W < 1 || PTR_W > 8)
      $error("twi_slave: PTR_W must be 1..8");
    if (NUM_REGS < 1 || NUM_REGS > (1 << PTR_W))
      $error("twi_slave: NUM_REGS does not fit PTR_W");
  end

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_bit_cnt    = bit_cnt_ff;
    nxt_shift      = shift_ff;
    nxt_ptr        = ptr_ff;
    nxt_ptr_loaded = ptr_loaded_ff;
    nxt_rd_mode    = rd_mode_ff;
    nxt_sda_drv    = sda_drv_ff;
    nxt_busy       = busy_ff;
    nxt_swrst      = swrst_ff;
    nxt_ack_pend   = ack_pend_ff;
    wr_en          = 1'b0;

    if (start_det)
    begin
      // repeated start behaves exactly as a fresh start
      nxt_state      = ST_ADDR; // [RULE12]
      nxt_bit_cnt    = twi_slave_pkg::BIT_CNT_RESET; // [RULE24]
      nxt_sda_drv    = 1'b0;
      nxt_ptr_loaded = 1'b0;
      nxt_busy       = 1'b1;
    end
    else if (stop_det)
    begin
      // stop ends the transfer and lifts the soft reset with it
      nxt_state   = ST_IDLE; // [RULE24]
      nxt_bit_cnt = twi_slave_pkg::BIT_CNT_RESET;
      nxt_sda_drv = 1'b0; // [RULE5]
      nxt_busy    = 1'b0;
      nxt_swrst   = 1'b0; // [RULE21]
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          nxt_sda_drv = 1'b0; // [RULE23]
        end
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            nxt_shift   = {shift_ff[6:0], sda_s}; // [RULE6]
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
          if (scl_fall && bit_cnt_ff == twi_slave_pkg::BIT_CNT_LAST + 4'h1)
          begin
            nxt_bit_cnt = twi_slave_pkg::BIT_CNT_RESET;
            if (state_ff == ST_ADDR)
            begin
              if (shift_ff[7:1] == twi_slave_pkg::DEV_ADDR) // [RULE13]
              begin
                nxt_rd_mode = shift_ff[0]; // [RULE14]
                nxt_sda_drv = 1'b1; // [RULE14]
                nxt_state   = ST_ACK;
              end
              else
                nxt_state = ST_IDLE; // [RULE23]
            end
            else
            begin
              if (!ptr_loaded_ff)
              begin
                // only the low bits are kept, so the pointer wraps in the map
                nxt_ptr        = shift_ff[PTR_W-1:0]; // [RULE15] [RULE22]
                nxt_ptr_loaded = 1'b1;
              end
              else
              begin
                wr_en   = 1'b1; // [RULE16]
                nxt_ptr = ptr_ff + 1'b1; // [RULE17]
                if (shift_ff == twi_slave_pkg::SWRST_REG_IDX &&
                    ptr_ff == twi_slave_pkg::SWRST_REG_IDX[PTR_W-1:0])
                  nxt_swrst = 1'b0;
                if (ptr_ff == twi_slave_pkg::SWRST_REG_IDX[PTR_W-1:0] && shift_ff[twi_slave_pkg::SWRST_BIT_POS])
                  nxt_swrst = 1'b1; // [RULE21]
              end
              nxt_sda_drv = 1'b1; // [RULE8]
              nxt_state   = ST_ACK;
            end
          end
        end
        ST_ACK:
        begin
          // ack held low across the whole ninth pulse; on its fall released, or set to the first read bit
          if (scl_fall) // [RULE3]
          begin
            if (rd_mode_ff)
            begin
              nxt_shift   = rd_data; // [RULE19]
              nxt_sda_drv = ~rd_data[7]; // [RULE6]
              nxt_state   = ST_TX;
            end
            else
            begin
              nxt_sda_drv = 1'b0; // [RULE8]
              nxt_state   = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_ff == twi_slave_pkg::BIT_CNT_LAST)
            begin
              nxt_sda_drv = 1'b0; // [RULE8]
              nxt_bit_cnt = twi_slave_pkg::BIT_CNT_RESET;
              nxt_ptr     = ptr_ff + 1'b1; // [RULE19]
              nxt_state   = ST_MACK;
            end
            else
            begin
              nxt_shift   = {shift_ff[6:0], 1'b0};
              nxt_sda_drv = ~shift_ff[6]; // [RULE3]
              nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          // master answer sampled at the pulse rise, acted on at its fall
          if (scl_rise)
            nxt_ack_pend = ~sda_s;
          if (scl_fall)
          begin
            if (ack_pend_ff)
            begin
              nxt_shift   = rd_data;
              nxt_sda_drv = ~rd_data[7];
              nxt_state   = ST_TX;
            end
            else
            begin
              nxt_sda_drv = 1'b0; // [RULE11]
              nxt_state   = ST_IDLE; // [RULE11]
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_d_ff      <= 1'b1;
      sda_d_ff      <= 1'b1;
      state_ff      <= ST_IDLE;
      bit_cnt_ff    <= twi_slave_pkg::BIT_CNT_RESET;
      shift_ff      <= 8'h00;
      ptr_ff        <= '0;
      ptr_loaded_ff <= 1'b0;
      rd_mode_ff    <= 1'b0;
      sda_drv_ff    <= 1'b0;
      busy_ff       <= 1'b0;
      swrst_ff      <= 1'b0;
      ack_pend_ff   <= 1'b0;
    end
    else
    begin
      scl_d_ff      <= scl_s;
      sda_d_ff      <= sda_s;
      state_ff      <= nxt_state;
      bit_cnt_ff    <= nxt_bit_cnt;
      shift_ff      <= nxt_shift;
      ptr_ff        <= nxt_ptr;
      ptr_loaded_ff <= nxt_ptr_loaded;
      rd_mode_ff    <= nxt_rd_mode;
      sda_drv_ff    <= nxt_sda_drv;
      busy_ff       <= nxt_busy;
      swrst_ff      <= nxt_swrst;
      ack_pend_ff   <= nxt_ack_pend;
    end
  end

  // open drain: only ever pull low
  assign sda_o                = 1'b0; // [RULE2]
  assign sda_oe_o             = sda_drv_ff; // [RULE2]
  assign software_reset_bit_o = swrst_ff; // [RULE21]
  assign busy_o               = busy_ff;
endmodule

// ---- tb/twi_slave_checker.sv ----
// Purpose: port-level timing checks for the two-wire slave
// Assumes: bus clock far slower than sys_clk_i
// Notes:   attached by bind below
`timescale 1ns/1ps
module twi_slave_checker
#(
  parameter int NUM_REGS = 16,
  parameter int PTR_W    = 4
)
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic software_reset_bit_o,
  input wire logic busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_drive_low_only: assert property (sda_o == 1'b0) else $error("data driven high");
  a_idle_released: assert property (!busy_o |-> !sda_oe_o) else $error("data held while idle");
  a_start_busy: assert property ($fell(sda_i) && scl_i |-> ##[1:6] busy_o) else $error("start missed");
  a_stop_idle: assert property ($rose(sda_i) && scl_i |-> ##[1:6] !busy_o) else $error("stop missed");
  a_change_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
  a_hold_clk_high: assert property ($rose(scl_i) |-> ##1 $stable(sda_oe_o)[*3]) else $error("data unstable");
  a_swrst_in_xfer: assert property ($rose(software_reset_bit_o) |-> busy_o) else $error("soft reset idle");
  a_swrst_clears: assert property ($fell(busy_o) |-> ##[0:2] !software_reset_bit_o) else $error("soft reset stuck");
endmodule
bind twi_slave twi_slave_checker #(.NUM_REGS(NUM_REGS), .PTR_W(PTR_W)) u_chk (.sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .software_reset_bit_o(software_reset_bit_o), .busy_o(busy_o));

// ---- tb/twi_master_model.sv ----
// Purpose: behavioural bus master driving clock and open-drain data
// Assumes: clock low 5 and high 3 sys clocks, 800 ns period
// Notes:   data bits change mid-low; start and stop move data with clock high
`timescale 1ns/1ps
module twi_master_model
(
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic bit_x(input logic b, output logic r);
    wt(2);
    sda_low_o <= ~b;
    wt(3);
    r = sda_i;
    scl_o <= 1'b1;
    wt(3);
    scl_o <= 1'b0;
  endtask
  // also serves as repeated start
  task automatic start();
    wt(2);
    sda_low_o <= 1'b0;
    wt(3);
    scl_o <= 1'b1;
    wt(3);
    sda_low_o <= 1'b1;
    wt(3);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_low_o <= 1'b1;
    wt(3);
    scl_o <= 1'b1;
    wt(3);
    sda_low_o <= 1'b0;
    wt(3);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ak_tx, output logic [7:0] rx, output logic ak_rx);
    for (int i = 7; i >= 0; i--)
      bit_x(tx[i], rx[i]);
    bit_x(ak_tx, ak_rx);
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the two-wire slave
// Assumes: register model mirrors written bytes
// Notes:   pointer wraps in four bits
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk;
  logic        arst_n;
  logic        scl;
  logic        sda_low;
  logic        sda_oe;
  logic        swrst;
  logic        busy;
  logic [7:0]  rx;
  logic        ak;
  logic [31:0] seed;
  logic [7:0]  mem [16];
  int          ptr;
  int          errors;
  int          cmp_count;
  wire logic   sda_w = ~(sda_low | sda_oe);
  twi_master_model m (.sys_clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
  twi_slave #(.NUM_REGS(16), .PTR_W(4)) dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .scl_i(scl),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .software_reset_bit_o(swrst), .busy_o(busy));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr_seq(input logic [7:0] p, input int n);
    logic [7:0] d;
    m.start();
    m.xfer(8'h2a, 1'b1, rx, ak);
    chk("addr ack", {7'h00, ak}, 8'h00);
    m.xfer(p, 1'b1, rx, ak);
    chk("ptr ack", {7'h00, ak}, 8'h00);
    ptr = p % 16;
    for (int i = 0; i < n; i++)
    begin
      d = 8'(xs());
      m.xfer(d, 1'b1, rx, ak);
      chk("data ack", {7'h00, ak}, 8'h00);
      mem[ptr] = d;
      ptr = (ptr + 1) % 16;
    end
  endtask
  task automatic rd_seq(input int n);
    m.start();
    m.xfer(8'h2b, 1'b1, rx, ak);
    chk("rd addr ack", {7'h00, ak}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      m.xfer(8'hff, (i == n - 1), rx, ak);
      chk("rd data", rx, mem[ptr]);
      ptr = (ptr + 1) % 16;
    end
    m.stop();
    // stop is seen two flops late and registered one edge after that
    m.wt(2);
    chk("busy after stop", {7'h00, busy}, 8'h00);
  endtask
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end
  initial
  begin
    logic [7:0] p;
    int n;
    seed = 37;
    errors = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    foreach (mem[i])
      mem[i] = 8'h00;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    m.wt(4);
    chk("busy reset", {7'h00, busy}, 8'h00);
    for (int r = 0; r < 6; r++)
    begin
      p = (r == 0) ? 8'h0e : {4'h0, 4'(xs())};
      n = 1 + (xs() % 4);
      wr_seq(p, n);
      m.stop();
      wr_seq(p, 0);
      rd_seq(n + 1);
    end
    $display("test write read done");
    m.start();
    m.xfer(8'h2c, 1'b1, rx, ak);
    chk("foreign addr", {7'h00, ak}, 8'h01);
    m.xfer(8'h2a, 1'b1, rx, ak);
    chk("ignored byte", {7'h00, ak}, 8'h01);
    m.stop();
    $display("test foreign address done");
    wr_seq(8'h03, 0);
    for (int i = 0; i < 4; i++)
      m.bit_x(1'b0, ak);
    m.stop();
    wr_seq(8'h03, 0);
    rd_seq(2);
    // a start cutting into a byte must restart the address phase
    wr_seq(8'h05, 0);
    for (int i = 0; i < 3; i++)
      m.bit_x(1'b1, ak);
    rd_seq(1);
    $display("test abort done");
    m.start();
    m.xfer(8'h2a, 1'b1, rx, ak);
    m.xfer(8'h01, 1'b1, rx, ak);
    m.xfer(8'h10, 1'b1, rx, ak);
    mem[1] = 8'h10;
    chk("swrst ack", {7'h00, ak}, 8'h00);
    m.wt(4);
    chk("swrst set", {7'h00, swrst}, 8'h01);
    m.stop();
    m.wt(4);
    chk("swrst clear", {7'h00, swrst}, 8'h00);
    $display("test soft reset done");
    give_verdict();
  end
endmodule
